// File: core/cesf_map.vh
// register offsets, field positions and reset values of the crypto status-flag block
`ifndef CESF_MAP_VH
`define CESF_MAP_VH

// ************************************************************
// register word offsets
// ************************************************************
`define CESF_ADDR_W         4
`define CESF_DATA_W         16
`define CESF_OFS_STATUS     4'h0
`define CESF_OFS_CONTROL    4'h1
`define CESF_OFS_CONFIG     4'h2
`define CESF_OFS_EVT        4'h3
`define CESF_OFS_MASK       4'h4

// ************************************************************
// crypto_status bits
// ************************************************************
`define CESF_ST_ENGINE_BUSY 7
`define CESF_ST_TEXT_A_BUSY 6
`define CESF_ST_ABORT       5
`define CESF_ST_WRAP        4
`define CESF_ST_MODE_FAIL   2
`define CESF_ST_KEY_FAIL    1
`define CESF_ST_PGM_FAIL    0

// ************************************************************
// control bits
// ************************************************************
`define CESF_CT_GO          0
`define CESF_CT_WSTROBE     1
`define CESF_CT_MODRST      2
`define CESF_CT_ENABLE      3

// ************************************************************
// config fields
// ************************************************************
`define CESF_CF_OPMODE_LO   0
`define CESF_CF_CIPHER      3
`define CESF_CF_KEYMOD_LO   4
`define CESF_CF_KEYSRC_LO   6
`define CESF_CF_KEY_PAGE_SELECT_LO    10
`define CESF_CF_USED_MSB    13

// ************************************************************
// encodings and event bits
// ************************************************************
`define CESF_OPMODE_CTR     3'h4
`define CESF_OPMODE_LAST    3'h4
`define CESF_EV_DONE        0
`define CESF_EV_ABORT       1
`define CESF_EV_WRAP        2
`define CESF_EV_W           3
`define CESF_RESET_WORD     16'h0000

`endif

// File: core/cesf_cfg_check.v
// configuration checker: mode, key and key-page validity
`timescale 1ns/100ps
`default_nettype none
`include "cesf_map.vh"

module cesf_cfg_check #(
  parameter [15:0] KEY_SRC_OK    = 16'hffff,
  parameter [15:0] PAGE_RESERVED = 16'h0001
) (
  input  wire [2:0]  op_mode_i,
  input  wire        cipher_aes_i,
  input  wire [1:0]  key_mod_i,
  input  wire [3:0]  key_src_i,
  input  wire [3:0]  key_page_i,
  input  wire [15:0] page_locked_i,
  output wire        mode_bad_o,
  output wire        key_bad_o,
  output wire        page_bad_o
);

  // picks one bit of a 16-entry table by a 4-bit index
  function pick16;
    input [15:0] tbl;
    input [3:0]  idx;
    begin
      pick16 = tbl[idx];
    end
  endfunction

  // codes above counter mode are reserved
  assign mode_bad_o = (op_mode_i > `CESF_OPMODE_LAST);

  // des reserves key mode 2, aes reserves key mode 3
  assign key_bad_o  = (cipher_aes_i ? (key_mod_i == 2'h3) : (key_mod_i == 2'h2)) |
                      ~pick16(KEY_SRC_OK, key_src_i);

  assign page_bad_o = pick16(PAGE_RESERVED, key_page_i) | pick16(page_locked_i, key_page_i);

endmodule
`default_nettype wire

// File: core/cesf_status.v
// status-flag logic of the crypto engine with its register port
//
// Operation
// RQ1: status bits 15..8 and 3 read zero
// RQ2: engine busy while cipher or otp operation runs
// RQ3: text-a busy flag; software avoids buffer then
// RQ4: abort set on software go clear; clearable
// RQ5: wrap flag set; blocks go until cleared
// RQ6: mode fail tracks config, blocks write strobe
// RQ7: key fail tracks config, blocks write strobe
// RQ8: program fail on locked page, blocks programming
// RQ9: busy and fail flags cleared by module reset
// RQ10: abort, wrap cleared by reset or go clear
// RQ11: fail flags evaluate while module disabled
// RQ12: busy, key, program fail forced during otp read
// RQ13: forced flags settle after otp read ends
// RQ14: no start while abort flag set
// RQ15: only abort and wrap accept software clearing
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cesf_map.vh"

module cesf_status #(
  parameter [15:0] KEY_SRC_OK    = 16'hffff,
  parameter [15:0] PAGE_RESERVED = 16'h0001
) (
  input  wire                    mclk_i,
  input  wire                    rst_n_i,
  input  wire [`CESF_ADDR_W-1:0] addr_i,
  input  wire [`CESF_DATA_W-1:0] wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [`CESF_DATA_W-1:0] rdata_o,
  input  wire                    op_running_i,
  input  wire                    op_done_i,
  input  wire                    otp_busy_i,
  input  wire                    otp_read_i,
  input  wire                    otp_done_i,
  input  wire                    text_a_in_use_i,
  input  wire                    counter_wrap_i,
  input  wire [15:0]             page_locked_i,
  output wire                    go_o,
  output wire                    write_strobe_o,
  output wire                    module_enable_o,
  output wire                    start_o,
  output wire                    program_start_o,
  output wire                    irq_o
);

  // ************************************************************
  // registers
  // ************************************************************
  reg        engine_busy_ff;
  reg        text_a_busy_ff;
  reg        abort_ff;
  reg        wrap_ff;
  reg        mode_fail_ff;
  reg        key_fail_ff;
  reg        pgm_fail_ff;
  reg        go_ff;
  reg        wstrobe_ff;
  reg        modrst_ff;
  reg        enable_ff;
  reg [`CESF_CF_USED_MSB:0] cfg_ff;
  reg [`CESF_EV_W-1:0] evt_ff;
  reg [`CESF_EV_W-1:0] mask_ff;
  reg        start_ff;
  reg        pgm_start_ff;

  reg        nxt_engine_busy;
  reg        nxt_text_a_busy;
  reg        nxt_abort;
  reg        nxt_wrap;
  reg        nxt_mode_fail;
  reg        nxt_key_fail;
  reg        nxt_pgm_fail;
  reg        nxt_go;
  reg        nxt_wstrobe;
  reg        nxt_modrst;
  reg        nxt_enable;
  reg [`CESF_CF_USED_MSB:0] nxt_cfg;
  reg [`CESF_EV_W-1:0] nxt_evt;
  reg [`CESF_EV_W-1:0] nxt_mask;
  reg [`CESF_DATA_W-1:0] nxt_rdata;

  wire       mode_bad;
  wire       key_bad;
  wire       page_bad;
  wire [`CESF_DATA_W-1:0] status_word;
  wire [`CESF_DATA_W-1:0] control_word;

  // ************************************************************
  // decoded strobes
  // ************************************************************
  // true when the register port writes the word at the given offset
  function wr_hit;
    input                    wr;
    input [`CESF_ADDR_W-1:0] addr;
    input [`CESF_ADDR_W-1:0] ofs;
    begin
      wr_hit = wr & (addr == ofs);
    end
  endfunction

  wire wr_status  = wr_hit(wr_i, addr_i, `CESF_OFS_STATUS);
  wire wr_control = wr_hit(wr_i, addr_i, `CESF_OFS_CONTROL);
  wire wr_config  = wr_hit(wr_i, addr_i, `CESF_OFS_CONFIG);
  wire wr_evt     = wr_hit(wr_i, addr_i, `CESF_OFS_EVT);
  wire wr_mask    = wr_hit(wr_i, addr_i, `CESF_OFS_MASK);

  wire any_fail   = mode_fail_ff | key_fail_ff | pgm_fail_ff;
  wire ctr_mode   = (cfg_ff[`CESF_CF_OPMODE_LO +: 3] == `CESF_OPMODE_CTR);
  // a counter wrap only counts while a counter-mode operation runs
  wire wrap_hit   = go_ff & ctr_mode & counter_wrap_i;

  // software drops go while hardware has not finished
  wire sw_go_clear = wr_control & go_ff & ~wdata_i[`CESF_CT_GO] & ~op_done_i;
  // hardware ends the operation normally
  wire hw_go_clear = go_ff & op_done_i;
  wire go_request  = wr_control & ~go_ff & wdata_i[`CESF_CT_GO];
  // go is refused while aborted, wrapped, disabled or misconfigured
  wire go_allowed  = ~abort_ff & ~wrap_ff & enable_ff & ~any_fail & ~modrst_ff;  // see RQ14 see RQ5
  wire ws_request  = wr_control & ~wstrobe_ff & wdata_i[`CESF_CT_WSTROBE];
  wire ws_allowed  = ~any_fail & ~modrst_ff & ~otp_read_i;  // see RQ6 see RQ7 see RQ8

  // ************************************************************
  // configuration checker, kept live regardless of module enable
  // ************************************************************
  cesf_cfg_check #(
    .KEY_SRC_OK    (KEY_SRC_OK),
    .PAGE_RESERVED (PAGE_RESERVED)
  ) cesf_cfg_check_inst (
    .op_mode_i     (cfg_ff[`CESF_CF_OPMODE_LO +: 3]),
    .cipher_aes_i  (cfg_ff[`CESF_CF_CIPHER]),
    .key_mod_i     (cfg_ff[`CESF_CF_KEYMOD_LO +: 2]),
    .key_src_i     (cfg_ff[`CESF_CF_KEYSRC_LO +: 4]),
    .key_page_i    (cfg_ff[`CESF_CF_KEY_PAGE_SELECT_LO +: 4]),
    .page_locked_i (page_locked_i),
    .mode_bad_o    (mode_bad),
    .key_bad_o     (key_bad),
    .page_bad_o    (page_bad)
  );

  // ************************************************************
  // control and configuration
  // ************************************************************
  always @* begin
    nxt_modrst  = modrst_ff;
    nxt_enable  = enable_ff;
    nxt_cfg     = cfg_ff;
    nxt_go      = go_ff;
    nxt_wstrobe = wstrobe_ff;
    if (wr_control) begin
      nxt_modrst = wdata_i[`CESF_CT_MODRST];
      nxt_enable = wdata_i[`CESF_CT_ENABLE];
    end
    // config is frozen while an operation is in progress
    if (wr_config && !go_ff) begin
      nxt_cfg = wdata_i[`CESF_CF_USED_MSB:0];
    end
    if (go_request && go_allowed) begin
      nxt_go = 1'b1;
    end else if (sw_go_clear || hw_go_clear) begin
      nxt_go = 1'b0;
    end
    if (ws_request && ws_allowed) begin
      nxt_wstrobe = 1'b1;
    end else if (otp_done_i) begin
      nxt_wstrobe = 1'b0;
    end
    // module reset takes hold one edge after its write, so a go in that
    // same write still starts; software should write the reset on its own
    if (modrst_ff) begin
      nxt_go      = 1'b0;
      nxt_wstrobe = 1'b0;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always @* begin
    nxt_engine_busy = op_running_i | otp_busy_i | go_ff | wstrobe_ff;  // see RQ2
    nxt_text_a_busy = text_a_in_use_i;  // see RQ3
    // fail flags follow the live config even with the module off; see RQ11
    nxt_mode_fail   = mode_bad;  // see RQ6
    nxt_key_fail    = key_bad;  // see RQ7
    nxt_pgm_fail    = page_bad;  // see RQ8
    // forced high while the otp array is read, released when it ends; see RQ13
    if (otp_read_i) begin
      nxt_engine_busy = 1'b1;  // see RQ12
      nxt_key_fail    = 1'b1;  // see RQ12
      nxt_pgm_fail    = 1'b1;  // see RQ12
    end

    nxt_abort = abort_ff;
    nxt_wrap  = wrap_ff;
    // a normal finish clears the sticky pair, a set in the same cycle still wins
    if (hw_go_clear) begin
      nxt_abort = 1'b0;  // see RQ10
      nxt_wrap  = 1'b0;  // see RQ10
    end
    // software may clear only these two by writing ones
    if (wr_status && wdata_i[`CESF_ST_ABORT]) begin
      nxt_abort = 1'b0;  // see RQ15 see RQ4
    end
    if (wr_status && wdata_i[`CESF_ST_WRAP]) begin
      nxt_wrap = 1'b0;  // see RQ15 see RQ5
    end
    if (sw_go_clear) begin
      nxt_abort = 1'b1;  // see RQ4
    end
    if (wrap_hit) begin
      nxt_wrap = 1'b1;  // see RQ5
    end

    // module reset holds every flag at its reset state
    if (modrst_ff) begin
      nxt_engine_busy = 1'b0;  // see RQ9
      nxt_text_a_busy = 1'b0;  // see RQ9
      nxt_mode_fail   = 1'b0;  // see RQ9
      nxt_key_fail    = 1'b0;  // see RQ9
      nxt_pgm_fail    = 1'b0;  // see RQ9
      nxt_abort       = 1'b0;  // see RQ10
      nxt_wrap        = 1'b0;  // see RQ10
    end
  end

  // ************************************************************
  // interrupt events
  // ************************************************************
  always @* begin
    nxt_mask = mask_ff;
    nxt_evt  = evt_ff;
    if (wr_mask) begin
      nxt_mask = wdata_i[`CESF_EV_W-1:0];
    end
    if (wr_evt) begin
      nxt_evt = evt_ff & ~wdata_i[`CESF_EV_W-1:0];
    end
    // sets come after the clear so a coincident event is kept
    if (hw_go_clear) begin
      nxt_evt[`CESF_EV_DONE] = 1'b1;
    end
    if (sw_go_clear && !modrst_ff) begin
      nxt_evt[`CESF_EV_ABORT] = 1'b1;
    end
    if (wrap_hit && !modrst_ff) begin
      nxt_evt[`CESF_EV_WRAP] = 1'b1;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // unimplemented bits stay tied low
  assign status_word = {8'h00,
                        engine_busy_ff,
                        text_a_busy_ff,
                        abort_ff,
                        wrap_ff,
                        1'b0,
                        mode_fail_ff,
                        key_fail_ff,
                        pgm_fail_ff};  // see RQ1

  assign control_word = {12'h000, enable_ff, modrst_ff, wstrobe_ff, go_ff};

  always @* begin
    nxt_rdata = `CESF_RESET_WORD;
    if (rd_i) begin
      case (addr_i)
        `CESF_OFS_STATUS: begin
          nxt_rdata = status_word;
        end
        `CESF_OFS_CONTROL: begin
          nxt_rdata = control_word;
        end
        `CESF_OFS_CONFIG: begin
          nxt_rdata = {{(`CESF_DATA_W-1-`CESF_CF_USED_MSB){1'b0}}, cfg_ff};
        end
        `CESF_OFS_EVT: begin
          nxt_rdata = {{(`CESF_DATA_W-`CESF_EV_W){1'b0}}, evt_ff};
        end
        `CESF_OFS_MASK: begin
          nxt_rdata = {{(`CESF_DATA_W-`CESF_EV_W){1'b0}}, mask_ff};
        end
        default: begin
          nxt_rdata = `CESF_RESET_WORD;
        end
      endcase
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      engine_busy_ff <= 1'b0;
      text_a_busy_ff <= 1'b0;
      abort_ff       <= 1'b0;
      wrap_ff        <= 1'b0;
      mode_fail_ff   <= 1'b0;
      key_fail_ff    <= 1'b0;
      pgm_fail_ff    <= 1'b0;
      go_ff          <= 1'b0;
      wstrobe_ff     <= 1'b0;
      modrst_ff      <= 1'b0;
      enable_ff      <= 1'b0;
      cfg_ff         <= {(`CESF_CF_USED_MSB+1){1'b0}};
      evt_ff         <= {`CESF_EV_W{1'b0}};
      mask_ff        <= {`CESF_EV_W{1'b0}};
      start_ff       <= 1'b0;
      pgm_start_ff   <= 1'b0;
      rdata_o        <= `CESF_RESET_WORD;
    end else begin
      engine_busy_ff <= nxt_engine_busy;
      text_a_busy_ff <= nxt_text_a_busy;
      abort_ff       <= nxt_abort;
      wrap_ff        <= nxt_wrap;
      mode_fail_ff   <= nxt_mode_fail;
      key_fail_ff    <= nxt_key_fail;
      pgm_fail_ff    <= nxt_pgm_fail;
      go_ff          <= nxt_go;
      wstrobe_ff     <= nxt_wstrobe;
      modrst_ff      <= nxt_modrst;
      enable_ff      <= nxt_enable;
      cfg_ff         <= nxt_cfg;
      evt_ff         <= nxt_evt;
      mask_ff        <= nxt_mask;
      start_ff       <= go_request & go_allowed & ~modrst_ff;  // see RQ14
      pgm_start_ff   <= ws_request & ws_allowed & ~modrst_ff;  // see RQ8
      rdata_o        <= nxt_rdata;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign go_o            = go_ff;
  assign write_strobe_o  = wstrobe_ff;
  assign module_enable_o = enable_ff;
  assign start_o         = start_ff;
  assign program_start_o = pgm_start_ff;
  assign irq_o           = |(evt_ff & mask_ff);

endmodule
`default_nettype wire

// File: tb/cesf_status_checker.sv
// concurrent assertions on the ports of the crypto status-flag block
`timescale 1ns/100ps
`default_nettype none
module cesf_status_checker (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        op_running_i,
  input wire logic        otp_read_i,
  input wire logic        text_a_in_use_i,
  input wire logic        go_o,
  input wire logic        write_strobe_o,
  input wire logic        start_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ************************************************************
  // status read and control relations
  // ************************************************************
  // inputs held two edges so either flag latency is covered
  wire logic rs = rd_i && addr_i == 4'h0;
  unimpl_zero_a: assert property (rs |=> rdata_o[15:8] == 8'h00 && !rdata_o[3])
    else $error("unimplemented status bits read nonzero");
  busy_op_a: assert property (rs && op_running_i && $past(op_running_i) |=> rdata_o[7])
    else $error("engine busy low while operation runs");
  busy_go_a: assert property (rs && go_o && $past(go_o) |=> rdata_o[7])
    else $error("engine busy low while go set");
  text_busy_a: assert property (rs && text_a_in_use_i && $past(text_a_in_use_i) |=> rdata_o[6])
    else $error("text a busy low while buffer in use");
  otp_force_a: assert property (rs && otp_read_i && $past(otp_read_i) |=> rdata_o[7] && rdata_o[1] && rdata_o[0])
    else $error("flags not forced during otp read");
  strobe_block_a: assert property (wr_i && addr_i == 4'h1 && wdata_i[1] && otp_read_i && !write_strobe_o |=> !write_strobe_o)
    else $error("write strobe set during otp read");
  start_cause_a: assert property (start_o |-> go_o && $past(wr_i && addr_i == 4'h1 && wdata_i[0]))
    else $error("start without accepted go write");
  modrst_a: assert property (wr_i && addr_i == 4'h1 && wdata_i[2] |=> ##1 !go_o && !write_strobe_o && !start_o)
    else $error("module reset left go or strobe set");
endmodule
bind cesf_status cesf_status_checker cesf_status_checker_inst (
  .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .op_running_i,
  .otp_read_i, .text_a_in_use_i, .go_o, .write_strobe_o, .start_o
);
`default_nettype wire

// File: tb/cesf_status_tb.sv
// self-checking bench of the crypto status-flag block
`timescale 1ns/100ps
`default_nettype none
`include "cesf_map.vh"
module cesf_status_tb;
  localparam [3:0] ST = `CESF_OFS_STATUS;
  localparam [3:0] CT = `CESF_OFS_CONTROL;
  localparam [3:0] CF = `CESF_OFS_CONFIG;
  localparam [3:0] EV = `CESF_OFS_EVT;
  localparam [3:0] MK = `CESF_OFS_MASK;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic        op_running_i = 1'b0, op_done_i = 1'b0, otp_busy_i = 1'b0;
  logic        otp_read_i = 1'b0, otp_done_i = 1'b0;
  logic        text_a_in_use_i = 1'b0, counter_wrap_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, page_locked_i = 16'h0000, v;
  logic        stv, psv;
  int          error_cnt = 0, checked = 0;
  wire [15:0]  rdata_o;
  wire         go_o, write_strobe_o, module_enable_o, start_o, program_start_o, irq_o;
  cesf_status cesf_status_inst (
    .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .op_running_i,
    .op_done_i, .otp_busy_i, .otp_read_i, .otp_done_i, .text_a_in_use_i,
    .counter_wrap_i, .page_locked_i, .go_o, .write_strobe_o, .module_enable_o,
    .start_o, .program_start_o, .irq_o
  );
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
    stv = start_o;
    psv = program_start_o;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    @(posedge mclk_i);
  endtask
  // two idle edges let a level change reach the status word
  task automatic cs(input logic [15:0] e);
    repeat (2) @(posedge mclk_i);
    rd(ST);
    chk(v, e);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    cs(16'h0001);
    wr(ST, 16'hffff);
    cs(16'h0001);
    wr(4'h9, 16'hffff);
    rd(CT);
    chk(v, 16'h0000);
    rd(4'hf);
    chk(v, 16'h0000);
    $display("done t_reset");
  endtask
  task automatic t_busy();
    op_running_i <= 1'b1;
    text_a_in_use_i <= 1'b1;
    cs(16'h00c1);
    op_running_i <= 1'b0;
    text_a_in_use_i <= 1'b0;
    otp_busy_i <= 1'b1;
    cs(16'h0081);
    otp_busy_i <= 1'b0;
    cs(16'h0001);
    $display("done t_busy");
  endtask
  // module stays disabled throughout, fail flags still track
  task automatic t_fail();
    wr(CF, 16'h0405);
    cs(16'h0004);
    wr(CT, 16'h0002);
    chk(16'(write_strobe_o), 16'h0000);
    wr(CF, 16'h043c);
    cs(16'h0002);
    wr(CT, 16'h0002);
    chk(16'(write_strobe_o), 16'h0000);
    page_locked_i <= 16'h0002;
    wr(CF, 16'h0400);
    cs(16'h0001);
    wr(CT, 16'h0002);
    chk(16'(write_strobe_o | psv), 16'h0000);
    page_locked_i <= 16'h0000;
    cs(16'h0000);
    wr(CT, 16'h0002);
    chk(16'({write_strobe_o, psv}), 16'h0003);
    cs(16'h0080);
    otp_done_i <= 1'b1;
    @(posedge mclk_i);
    otp_done_i <= 1'b0;
    cs(16'h0000);
    $display("done t_fail");
  endtask
  task automatic t_otp();
    otp_read_i <= 1'b1;
    wr(CT, 16'h0002);
    chk(16'(write_strobe_o), 16'h0000);
    cs(16'h0083);
    otp_read_i <= 1'b0;
    cs(16'h0000);
    $display("done t_otp");
  endtask
  task automatic t_wrap();
    wr(CF, 16'h0404);
    wr(CT, 16'h0008);
    chk(16'(module_enable_o), 16'h0001);
    wr(CT, 16'h0009);
    chk(16'({go_o, stv}), 16'h0003);
    counter_wrap_i <= 1'b1;
    @(posedge mclk_i);
    counter_wrap_i <= 1'b0;
    cs(16'h0090);
    wr(CT, 16'h0008);
    cs(16'h0030);
    wr(CT, 16'h0009);
    chk(16'({go_o, stv}), 16'h0000);
    wr(MK, 16'h0000);
    chk(16'(irq_o), 16'h0000);
    wr(MK, 16'h0004);
    chk(16'(irq_o), 16'h0001);
    wr(EV, 16'h0006);
    chk(16'(irq_o), 16'h0000);
    wr(ST, 16'h00ff);
    cs(16'h0000);
    wr(CT, 16'h0009);
    chk(16'(go_o), 16'h0001);
    counter_wrap_i <= 1'b1;
    @(posedge mclk_i);
    counter_wrap_i <= 1'b0;
    op_done_i <= 1'b1;
    @(posedge mclk_i);
    op_done_i <= 1'b0;
    cs(16'h0000);
    $display("done t_wrap");
  endtask
  task automatic t_modrst();
    wr(CT, 16'h0009);
    page_locked_i <= 16'h0002;
    wr(CT, 16'h000c);
    chk(16'(go_o), 16'h0000);
    cs(16'h0000);
    page_locked_i <= 16'h0000;
    wr(CT, 16'h0000);
    chk(16'(module_enable_o), 16'h0000);
    $display("done t_modrst");
  endtask
  task automatic print_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_busy();
    t_fail();
    t_otp();
    t_wrap();
    t_modrst();
    print_verdict();
  end
endmodule
`default_nettype wire
